// File: src/ps2_channel_controller.sv
// The Wishbone interface to the registers and the address map were decided locally.
`include "ps2_defs.svh"

module ps2_channel_controller
   import ps2_pkg::*;
#(
   parameter int DIR_WAIT = `DIR_WAIT_CYC
)
(
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // Wishbone slave
   input  wire logic [7:0]  adr_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   input  wire logic        we_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   output logic             ack_o,
   // Link clock line
   input  wire logic        link_clock_line_i,
   output logic             link_clock_line_o,
   output logic             link_clock_line_oe_n_o,
   // Link data line
   input  wire logic        link_data_line_i,
   output logic             link_data_line_o,
   output logic             link_data_line_oe_n_o,
   // Event
   output logic             irq_o
);

   // ----------------------------------------------------------------
   // Declarations
   // ----------------------------------------------------------------
   state_t      state_q;
   logic        ack_q;
   logic [31:0] dat_o_q;
   logic        clk_s1_q;
   logic        clk_s2_q;
   logic        clk_s3_q;
   logic        dat_s1_q;
   logic        dat_s2_q;
   logic        channel_enable_bit_q;
   logic        direction_select_bit_q;
   logic        transmit_idle_flag_q;
   logic        rx_ready_q;
   logic        parity_err_q;
   logic        stop_err_q;
   logic [7:0]  tx_data_q;
   logic [7:0]  rx_data_q;
   logic [10:0] shift_q;
   logic [3:0]  cnt_q;
   logic [6:0]  wait_q;
   logic        clk_oe_n_q;
   logic        dat_oe_n_q;
   logic        irq_q;
   logic        fall;
   logic        rise;
   logic        wr;
   logic        rd;
   logic        wr_ctrl;
   logic        wr_tx;
   logic        rd_rx;
   logic        rx_done;
   logic        tx_end;

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   assign wr      = cyc_i & stb_i & we_i & ack_q & sel_i[0];
   assign rd      = cyc_i & stb_i & ~we_i & ack_q;
   assign wr_ctrl = wr & (adr_i == `CTRL_OFS);
   assign wr_tx   = wr & (adr_i == `TX_OFS);
   assign rd_rx   = rd & (adr_i == `RX_OFS);

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         ack_q <= 1'b0;
      else
         ack_q <= cyc_i & stb_i & ~ack_q;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         dat_o_q <= 32'h0000_0000;
      else if (cyc_i & stb_i & ~ack_q & ~we_i)
      begin
         dat_o_q <= 32'h0000_0000;
         case (adr_i)
            `CTRL_OFS:
            begin
               dat_o_q[`CTRL_EN_BIT]  <= channel_enable_bit_q;
               dat_o_q[`CTRL_DIR_BIT] <= direction_select_bit_q;
            end
            `TX_OFS:   dat_o_q[7:0] <= tx_data_q;
            `RX_OFS:   dat_o_q[7:0] <= rx_data_q;
            `STAT_OFS:
            begin
               dat_o_q[`STAT_IDLE_BIT] <= transmit_idle_flag_q;
               dat_o_q[`STAT_RDY_BIT]  <= rx_ready_q;
               dat_o_q[`STAT_PERR_BIT] <= parity_err_q;
               dat_o_q[`STAT_SERR_BIT] <= stop_err_q;
            end
            default:   dat_o_q <= 32'h0000_0000;
         endcase
      end
   end

   assign ack_o = ack_q;
   assign dat_o = dat_o_q;

   // ----------------------------------------------------------------
   // Line synchronisers and edge detect
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         clk_s1_q <= 1'b1;
         clk_s2_q <= 1'b1;
         clk_s3_q <= 1'b1;
         dat_s1_q <= 1'b1;
         dat_s2_q <= 1'b1;
      end
      else
      begin
         clk_s1_q <= link_clock_line_i;
         clk_s2_q <= clk_s1_q;
         clk_s3_q <= clk_s2_q;
         dat_s1_q <= link_data_line_i;
         dat_s2_q <= dat_s1_q;
      end
   end

   assign fall = clk_s3_q & ~clk_s2_q;
   assign rise = ~clk_s3_q & clk_s2_q;

   assign rx_done = (state_q == ST_RX) & fall & (cnt_q == `FRAME_LAST);
   // direction clear timed from rise after eleventh fall
   assign tx_end  = (state_q == ST_TX_END) & (wait_q == 7'(DIR_WAIT - 1));

   // ----------------------------------------------------------------
   // Control register
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         channel_enable_bit_q   <= `CTRL_EN_RST;
         direction_select_bit_q <= `CTRL_DIR_RST;
      end
      else if (wr_ctrl)
      begin
         channel_enable_bit_q   <= dat_i[`CTRL_EN_BIT];
         direction_select_bit_q <= dat_i[`CTRL_DIR_BIT];
      end
      else if (tx_end)
         direction_select_bit_q <= 1'b0;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         tx_data_q <= 8'h00;
      else if (wr_tx)
         tx_data_q <= dat_i[7:0];
   end

   // ----------------------------------------------------------------
   // Status flags
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         transmit_idle_flag_q <= `STAT_IDLE_RST;
      else if (tx_end)
         transmit_idle_flag_q <= 1'b1;
      else if ((state_q == ST_TX_HOLD) & wr_tx)
         transmit_idle_flag_q <= 1'b0;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         rx_ready_q <= 1'b0;
      else if (rx_done)
         rx_ready_q <= 1'b1;
      else if (rd_rx)
         rx_ready_q <= 1'b0;
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         rx_data_q    <= 8'h00;
         parity_err_q <= 1'b0;
         stop_err_q   <= 1'b0;
      end
      else if (rx_done)
      begin
         rx_data_q    <= shift_q[9:2];
         parity_err_q <= ~(^shift_q[10:2]);
         stop_err_q   <= ~dat_s2_q;
      end
   end

   // ----------------------------------------------------------------
   // Channel sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state_q <= ST_IDLE;
         shift_q <= 11'h7FF;
         cnt_q   <= 4'h0;
         wait_q  <= 7'h00;
      end
      else if (!channel_enable_bit_q)
      begin
         state_q <= ST_IDLE;
         cnt_q   <= 4'h0;
      end
      else
      begin
         case (state_q)
            ST_IDLE:
            begin
               cnt_q  <= 4'h0;
               wait_q <= 7'h00;
               if (direction_select_bit_q)
                  state_q <= ST_TX_HOLD;
               else if (fall)
               begin
                  shift_q <= {dat_s2_q, shift_q[10:1]};
                  cnt_q   <= 4'h1;
                  state_q <= ST_RX;
               end
            end
            ST_RX:
            begin
               if (direction_select_bit_q)
                  state_q <= ST_TX_HOLD;
               else if (fall)
               begin
                  shift_q <= {dat_s2_q, shift_q[10:1]};
                  cnt_q   <= cnt_q + 4'h1;
                  if (cnt_q == `FRAME_LAST)
                     state_q <= ST_INHIBIT;
               end
            end
            ST_INHIBIT:
            begin
               if (direction_select_bit_q)
                  state_q <= ST_TX_HOLD;
               else if (rd_rx)
                  state_q <= ST_IDLE;
            end
            ST_TX_HOLD:
            begin
               if (!direction_select_bit_q)
                  state_q <= ST_IDLE;
               else if (wr_tx)
               begin
                  shift_q <= {1'b1, ~(^dat_i[7:0]), dat_i[7:0], 1'b0};
                  cnt_q   <= 4'h0;
                  state_q <= ST_TX;
               end
            end
            ST_TX:
            begin
               if (!direction_select_bit_q)
                  state_q <= ST_IDLE;
               else if (fall)
               begin
                  shift_q <= {1'b1, shift_q[10:1]};
                  cnt_q   <= cnt_q + 4'h1;
                  if (cnt_q == `FRAME_LAST)
                     state_q <= ST_TX_ACK;
               end
            end
            ST_TX_ACK:
            begin
               if (!direction_select_bit_q)
                  state_q <= ST_IDLE;
               else if (rise)
               begin
                  wait_q  <= 7'h00;
                  state_q <= ST_TX_END;
               end
            end
            ST_TX_END:
            begin
               wait_q <= wait_q + 7'h01;
               if (tx_end | !direction_select_bit_q)
                  state_q <= ST_IDLE;
            end
            default:
               state_q <= ST_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Line drivers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         clk_oe_n_q <= 1'b0;
      else if (!channel_enable_bit_q)
         clk_oe_n_q <= 1'b0;
      else
      begin
         case (state_q)
            ST_TX_HOLD: clk_oe_n_q <= 1'b0;
            ST_INHIBIT: clk_oe_n_q <= 1'b0;
            ST_IDLE:    clk_oe_n_q <= ~direction_select_bit_q;
            default:    clk_oe_n_q <= 1'b1;
         endcase
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         dat_oe_n_q <= 1'b1;
      else if (!channel_enable_bit_q)
         dat_oe_n_q <= 1'b1;
      else if (state_q == ST_TX)
         dat_oe_n_q <= shift_q[0];
      else
         dat_oe_n_q <= 1'b1;
   end

   assign link_clock_line_o      = 1'b0;
   assign link_data_line_o       = 1'b0;
   assign link_clock_line_oe_n_o = clk_oe_n_q;
   assign link_data_line_oe_n_o  = dat_oe_n_q;

   // ----------------------------------------------------------------
   // Interrupt pulse
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         irq_q <= 1'b0;
      else
         irq_q <= tx_end | rx_done;
   end

   assign irq_o = irq_q;

endmodule : ps2_channel_controller

// File: src/ps2_defs.svh
`ifndef PS2_DEFS_SVH
`define PS2_DEFS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define CTRL_OFS        8'h00
`define TX_OFS          8'h04
`define RX_OFS          8'h08
`define STAT_OFS        8'h0C

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CTRL_EN_BIT     0
`define CTRL_DIR_BIT    1
`define STAT_IDLE_BIT   0
`define STAT_RDY_BIT    1
`define STAT_PERR_BIT   2
`define STAT_SERR_BIT   3

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define CTRL_EN_RST     1'b0
`define CTRL_DIR_RST    1'b0
`define STAT_IDLE_RST   1'b1

// ----------------------------------------------------------------
// Frame and timing
// ----------------------------------------------------------------
`define FRAME_LAST      4'hA
`define CLK_PERIOD_NS   100
`define T_DIR_MIN_NS    3500
`define T_DIR_MAX_NS    7100
`define DIR_MIN_CYC     ((`T_DIR_MIN_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DIR_MAX_CYC     (`T_DIR_MAX_NS / `CLK_PERIOD_NS)
`define DIR_WAIT_CYC    ((`DIR_MIN_CYC + `DIR_MAX_CYC) / 2)

`endif

// File: src/ps2_pkg.sv
package ps2_pkg;

   // ----------------------------------------------------------------
   // Channel states, Gray along transmit path
   // ----------------------------------------------------------------
   typedef enum logic [2:0]
   {
      ST_IDLE    = 3'h0,
      ST_TX_HOLD = 3'h1,
      ST_TX      = 3'h3,
      ST_TX_ACK  = 3'h2,
      ST_TX_END  = 3'h6,
      ST_RX      = 3'h4,
      ST_INHIBIT = 3'h5
   } state_t;

endpackage : ps2_pkg

// File: testbench/ps2_properties.sv
module ps2_properties
#(
   parameter int DIR_WAIT = 53
)
(
   // Bus side
   input wire logic        clk_i,
   input wire logic        rst_i,
   input wire logic [7:0]  adr_i,
   input wire logic [31:0] dat_i,
   input wire logic        we_i,
   input wire logic [3:0]  sel_i,
   input wire logic        cyc_i,
   input wire logic        stb_i,
   input wire logic        ack_o,
   // Link side
   input wire logic        link_clock_line_i,
   input wire logic        link_clock_line_oe_n_o,
   input wire logic        link_data_line_oe_n_o,
   input wire logic        irq_o
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam int T_LO = 36;
   localparam int T_HI = 72;
   logic       arm_q, tx_q, wr, cw, tw;
   logic [3:0] fc_q;
   logic [4:0] since_q;
   assign wr = cyc_i && stb_i && we_i && ack_o && sel_i[0];
   assign cw = wr && adr_i == 8'h00;
   assign tw = wr && adr_i == 8'h04 && arm_q;
   always_ff @(posedge clk_i)
      if (rst_i || cw || tw)
         arm_q <= cw && dat_i[1:0] == 2'h3;
   always_ff @(posedge clk_i)
      if (rst_i || irq_o || tw)
         tx_q <= tw;
   always_ff @(posedge clk_i)
      if (rst_i || irq_o || wr || !link_clock_line_oe_n_o)
         fc_q <= 4'h0;
      else if ($fell(link_clock_line_i))
         fc_q <= fc_q + 4'h1;
   always_ff @(posedge clk_i)
      if (rst_i)
         since_q <= 5'h1F;
      else if ($fell(link_clock_line_i))
         since_q <= 5'h00;
      else if (since_q != 5'h1F)
         since_q <= since_q + 5'h01;
   // ------------------------------
   // Properties
   // ------------------------------
   default clocking dc @(posedge clk_i); endclocking
   default disable iff (rst_i);
   rx_float_a: assert property (cw && dat_i[1:0] == 2'h1 |-> ##[1:10]
      (link_clock_line_oe_n_o && link_data_line_oe_n_o)) else $error("lines not floated");
   tx_prep_a: assert property (cw && dat_i[1:0] == 2'h3 |-> ##[1:4]
      !link_clock_line_oe_n_o) else $error("clock not pulled");
   start_low_a: assert property (tw |-> ##[1:3] !link_data_line_oe_n_o)
      else $error("no start bit");
   tx_release_a: assert property (tw |-> ##[1:3] link_clock_line_oe_n_o)
      else $error("clock not released");
   bit_time_a: assert property (tx_q && $changed(link_data_line_oe_n_o) && fc_q != 4'h0 && fc_q < 4'hB
      |-> since_q < 5'h0B) else $error("bit late");
   tx_end_irq_a: assert property ($rose(link_clock_line_i) && fc_q == 4'hB && tx_q
      |-> ##[T_LO:T_HI] irq_o) else $error("transmit end mistimed");
   data_free_a: assert property (irq_o && tx_q |-> link_data_line_oe_n_o)
      else $error("data held");
   rx_ready_a: assert property ($fell(link_clock_line_i) && fc_q == 4'hA && !tx_q
      |-> ##[1:17] irq_o) else $error("ready late");
   rd_release_a: assert property (ack_o && cyc_i && !we_i && adr_i == 8'h08
      |-> ##[1:4] link_clock_line_oe_n_o) else $error("inhibit kept");
   off_hold_a: assert property (cw && !dat_i[0] |-> ##[1:5]
      (!link_clock_line_oe_n_o && link_data_line_oe_n_o)) else $error("disable levels");
   cover property (tw);
   cover property (irq_o && tx_q);
   cover property (irq_o && !tx_q);
endmodule : ps2_properties

bind ps2_channel_controller ps2_properties #(.DIR_WAIT(DIR_WAIT)) u_ps2_properties (.clk_i, .rst_i, .adr_i,
   .dat_i, .we_i, .sel_i, .cyc_i, .stb_i, .ack_o, .link_clock_line_i, .link_clock_line_oe_n_o,
   .link_data_line_oe_n_o, .irq_o);

// File: testbench/ps2_dev.sv
module ps2_dev
(
   // Wire levels
   input  wire logic clk_w,
   input  wire logic data_w,
   // Open-drain enables
   output logic      clk_oe_n_o,
   output logic      data_oe_n_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] got;
   logic       got_ok;
   initial {clk_oe_n_o, data_oe_n_o} = 2'h3;
   // ------------------------------
   // Frames
   // ------------------------------
   // eleven bit frame
   task send(input logic [7:0] b, input logic bp, input logic bs);
      logic [10:0] f;
      f = {~bs, ~^b ^ bp, b, 1'b0};
      wait (clk_w === 1'b1);
      #37;
      for (int i = 0; i < 11; i++)
      begin
         data_oe_n_o = f[i];
         #200;
         clk_oe_n_o = 1'b0;
         #400;
         clk_oe_n_o = 1'b1;
         #200;
      end
      data_oe_n_o = 1'b1;
   endtask : send
   task recv;
      logic [10:0] f;
      wait (data_w === 1'b0 && clk_w === 1'b1);
      #2037;
      for (int i = 0; i < 11; i++)
      begin
         if (i == 10)
            data_oe_n_o = 1'b0;
         clk_oe_n_o = 1'b0;
         #400;
         clk_oe_n_o = 1'b1;
         #350;
         f[i] = data_w;
         #50;
      end
      data_oe_n_o = 1'b1;
      got = f[7:0];
      got_ok = ^f[8:0] && f[9];
   endtask : recv
endmodule : ps2_dev

// File: testbench/test_ps2_channel_controller.sv
module test_ps2_channel_controller;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic [7:0]  adr_i = 8'h00;
   logic [31:0] dat_i = 32'h0;
   logic        we_i = 1'b0;
   logic [3:0]  sel_i = 4'hF;
   logic        cyc_i = 1'b0;
   logic        stb_i = 1'b0;
   logic [31:0] dat_o;
   logic        ack_o, irq_o, m_clk_oe_n, m_dat_oe_n;
   logic        link_clock_line_o, link_clock_line_oe_n_o, link_data_line_o, link_data_line_oe_n_o;
   wire logic   clk_w = (link_clock_line_oe_n_o | link_clock_line_o) & m_clk_oe_n;
   wire logic   dat_w = (link_data_line_oe_n_o | link_data_line_o) & m_dat_oe_n;
   int          errors = 0;
   int          num_checks = 0;
   int          seed = 66076;
   logic [31:0] exp_q[$];
   logic [7:0]  b;
   logic [3:0]  sel_n = 4'hF;

   ps2_channel_controller u_ps2_channel_controller
   (
      .clk_i, .rst_i, .adr_i, .dat_i, .dat_o, .we_i, .sel_i, .cyc_i, .stb_i, .ack_o,
      .link_clock_line_i(clk_w), .link_clock_line_o, .link_clock_line_oe_n_o,
      .link_data_line_i(dat_w), .link_data_line_o, .link_data_line_oe_n_o, .irq_o
   );
   ps2_dev u_ps2_dev (.clk_w, .data_w(dat_w), .clk_oe_n_o(m_clk_oe_n), .data_oe_n_o(m_dat_oe_n));

   initial forever #50 clk_i = ~clk_i;
   // ------------------------------
   // Tasks
   // ------------------------------
   task chk(input logic [31:0] s, input logic [31:0] e);
      num_checks++;
      if (s !== e)
      begin
         errors++;
         $display("mismatch at %0t: saw %h expected %h", $time, s, e);
      end
   endtask : chk
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      {cyc_i, stb_i, we_i, sel_i, adr_i, dat_i} <= {2'b11, w, sel_n, a, d};
      @(posedge clk_i);
      while (ack_o !== 1'b1)
         @(posedge clk_i);
      {cyc_i, stb_i, we_i} <= 3'h0;
   endtask : wb
   task rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      wb(1'b0, a, 32'h0);
   endtask : rd
   task pins(input logic [1:0] e);
      @(negedge clk_i);
      chk({30'h0, link_clock_line_oe_n_o, link_data_line_oe_n_o}, {30'h0, e});
   endtask : pins
   task wirq;
      repeat (3000) if (irq_o !== 1'b1) @(negedge clk_i);
      chk({31'h0, irq_o}, 32'h1);
   endtask : wirq
   task conclude;
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : conclude
   // ------------------------------
   // Read data scoreboard
   // ------------------------------
   always @(posedge clk_i)
      if (ack_o === 1'b1 && we_i === 1'b0 && exp_q.size() > 0)
         chk(dat_o, exp_q.pop_front());
   initial
   begin
      repeat (20000) @(posedge clk_i);
      errors++;
      conclude;
   end
   initial
   begin
      repeat (4) @(posedge clk_i);
      rst_i <= 1'b0;
      pins(2'b01);
      rd(8'h00, 32'h0);
      rd(8'h0C, 32'h1);
      wb(1'b1, 8'h10, 32'hFFFFFFFF);
      rd(8'h10, 32'h0);
      wb(1'b1, 8'h00, 32'h1);
      repeat (8) @(posedge clk_i);
      pins(2'b11);
      rd(8'h00, 32'h1);
      sel_n = 4'h0;
      wb(1'b1, 8'h00, 32'h3);
      sel_n = 4'hF;
      rd(8'h00, 32'h1);
      pins(2'b11);
      for (int i = 0; i < 4; i++)
      begin
         b = 8'($random(seed));
         fork
            u_ps2_dev.send(b, i == 1, i == 2);
         join_none
         wirq;
         pins(2'b01);
         rd(8'h0C, {28'h0, i == 2, i == 1, 2'b11});
         rd(8'h08, {24'h0, b});
         rd(8'h0C, {28'h0, i == 2, i == 1, 2'b01});
         pins(2'b11);
      end
      for (int i = 0; i < 2; i++)
      begin
         wb(1'b1, 8'h00, 32'h3);
         repeat (4) @(posedge clk_i);
         pins(2'b01);
         b = 8'($random(seed));
         fork
            u_ps2_dev.recv;
         join_none
         wb(1'b1, 8'h04, {24'h0, b});
         repeat (2) @(posedge clk_i);
         pins(2'b10);
         rd(8'h0C, 32'h0);
         wirq;
         chk({24'h0, u_ps2_dev.got}, {24'h0, b});
         chk({31'h0, u_ps2_dev.got_ok}, 32'h1);
         rd(8'h0C, 32'h1);
         rd(8'h00, 32'h1);
         pins(2'b11);
      end
      wb(1'b1, 8'h00, 32'h3);
      wb(1'b1, 8'h04, 32'h5A);
      wb(1'b1, 8'h00, 32'h1);
      repeat (2) @(posedge clk_i);
      pins(2'b11);
      rd(8'h00, 32'h1);
      wb(1'b1, 8'h00, 32'h0);
      repeat (4) @(posedge clk_i);
      pins(2'b01);
      conclude;
   end
endmodule : test_ps2_channel_controller
